// *** bench/block_ram_reset_sequencer_bench.sv ***
// Purpose: self-checking bench for the sequencer and block RAM pair
// Assumes: GUARD, HOLD and STEADY at their one-cycle defaults
// Notes: tallies reset cycles on the link and enables seen during them
`timescale 1ns/10ps
module block_ram_reset_sequencer_bench;
  import ram_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mode_e mode = MODE_RAM;
  logic init_on = 1'b1;
  logic keep = 1'b0;
  logic [3:0] req = 4'h0; // full, pointer, init, sync
  logic ce = 1'b0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic busy, full, empty;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W:0] fill;
  logic [DATA_W-1:0] mem [16];
  int mismatches = 0;
  int num_checks = 0;
  int rst_cyc, en_bad, sync_cyc, n;
  ram_rst_if lnk ();
  block_ram_reset_sequencer u_block_ram_reset_sequencer (
    .CORE_CLK(clk), .RST_N(rst_n), .MODE(mode), .INIT_ENABLE(init_on),
    .KEEP_ENABLES(keep), .REQ_FULL_RST(req[0]), .REQ_RPTR_CLR(req[1]),
    .REQ_INIT(req[2]), .REQ_SYNC_RST(req[3]), .USER_CE(ce), .USER_PUSH(push),
    .USER_POP(pop), .USER_ADDR(addr), .USER_WDATA(wdata), .BUSY(busy),
    .USER_RDATA(rdata), .USER_FULL(full), .USER_EMPTY(empty), .LNK(lnk.seq)
  );
  embedded_block_ram u_embedded_block_ram (
    .CORE_CLK(clk), .RST_N(rst_n), .LNK(lnk.ram), .FILL_LEVEL(fill)
  );
  rst_seq_checker u_rst_seq_checker (
    .CORE_CLK(clk), .RST_N(rst_n), .mode(lnk.mode), .clk_en(lnk.clk_en),
    .push_en(lnk.push_en), .pop_strobe(lnk.pop_strobe), .empty(lnk.empty),
    .full_rst(lnk.full_rst), .read_pointer_clear(lnk.read_pointer_clear),
    .chip_wide_init(lnk.chip_wide_init), .init_en(lnk.init_en), .sync_rst(lnk.sync_rst)
  );
  // 100 MHz core clock
  always #5 clk = ~clk;
  // tally reset cycles, and enables left open while gating
  always @(posedge clk) begin
    if (lnk.full_rst || lnk.read_pointer_clear || lnk.chip_wide_init) begin
      rst_cyc++;
      if (!keep && (lnk.pop_strobe || (!lnk.read_pointer_clear && (lnk.clk_en || lnk.push_en))))
        en_bad++;
    end
    if (lnk.sync_rst) sync_cyc++;
  end
  task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask : check_flag
  // resets expected on the link: init is dropped on preloaded contents
  function automatic int exp_resets(input int m, input int k);
    return (m == int'(MODE_ROM) && k == int'(KIND_INIT)) ? 0 : 1;
  endfunction : exp_resets
  // chip-wide init enable: forced on in fifo, forced off on rom
  function automatic logic exp_init_en(input int m, input logic on);
    return (m == int'(MODE_FIFO)) || (m == int'(MODE_RAM) && on);
  endfunction : exp_init_en
  // busy cycles left once the request pin drops: quiet, assert, recover
  function automatic int exp_wait(input logic kept, input int acts);
    int t;
    t = kept ? 2 * STEADY_CYC + RST_HOLD_CYC : 2 * GUARD_CYC + RST_HOLD_CYC;
    return (acts != 0) ? t : 0;
  endfunction : exp_wait
  // one request held over the synchroniser, then a bounded wait for idle
  task automatic run_req(input int k, input int exp_rst);
    int w;
    w = 0;
    rst_cyc = 0;
    en_bad = 0;
    req[k] = 1'b1;
    repeat (4) @(negedge clk);
    req[k] = 1'b0;
    while (busy !== 1'b0 && w < 40) begin
      @(negedge clk);
      w++;
    end
    repeat (2) @(negedge clk);
    check_val(9'(rst_cyc), 9'(exp_rst));
    check_val(9'(en_bad), 9'h000);
    check_flag(busy, 1'b0);
    check_val(9'(w), 9'(exp_wait(keep, exp_rst)));
  endtask : run_req
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // cut a hang short
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(41829));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check_flag(busy, 1'b0);
    {ce, push} = 2'h3;
    for (int i = 0; i < 16; i++) begin
      addr = 4'(i);
      wdata = 8'($urandom());
      mem[i] = wdata;
      @(negedge clk);
    end
    push = 1'b0;
    for (int i = 0; i < 16; i++) begin
      addr = 4'(i);
      repeat (3) @(negedge clk);
      check_val(9'(rdata), 9'(mem[i]));
    end
    // every kind in every mode, gated and with enables kept on
    for (int m = 0; m < 3; m++) begin
      for (int j = 0; j < 6; j++) begin
        mode = mode_e'(2'(m));
        keep = j[0];
        {ce, push, pop} = keep ? 3'h7 : 3'($urandom());
        addr = 4'($urandom());
        run_req(j / 2, exp_resets(m, j / 2));
        check_flag(lnk.init_en, exp_init_en(m, init_on));
      end
    end
    // fill, drain part way, then rewind the read side
    mode = MODE_FIFO;
    keep = 1'b0;
    {ce, push, pop} = 3'h0;
    run_req(0, 1);
    check_flag(empty, 1'b1);
    {ce, push} = 2'h3;
    repeat (16) @(negedge clk);
    check_flag(full, 1'b1);
    n = 1 + $urandom() % 8;
    {push, pop} = 2'h1;
    repeat (n) @(negedge clk);
    {ce, pop} = 2'h0;
    check_val(fill, 9'(16 - n));
    run_req(1, 1);
    check_val(fill, 9'h010);
    check_flag(full, 1'b1);
    run_req(0, 1);
    check_val(fill, 9'h000);
    check_flag(full, 1'b0);
    // sync reset alone: load a nonzero word first, then one pulse clears it
    mode = MODE_RAM;
    {ce, push} = 2'h3;
    addr = 4'($urandom());
    wdata = 8'($urandom()) | 8'h01;
    @(negedge clk);
    push = 1'b0;
    repeat (3) @(negedge clk);
    check_val(9'(rdata), 9'(wdata));
    ce = 1'b0;
    sync_cyc = 0;
    req[3] = 1'b1;
    repeat (8) @(negedge clk);
    req[3] = 1'b0;
    check_val(9'(sync_cyc), 9'h001);
    check_val(9'(rdata), 9'h000);
    init_on = 1'b0;
    @(negedge clk);
    check_flag(lnk.init_en, 1'b0);
    finish_test();
  end
endmodule : block_ram_reset_sequencer_bench

// *** bench/rst_seq_checker.sv ***
// Purpose: assertions on the link between sequencer and block RAM
// Assumes: GUARD, HOLD and STEADY left at one cycle
// Notes: a gated sequence shows push_en low while a reset is high, save a fifo pointer clear
`timescale 1ns/10ps
module rst_seq_checker
  import ram_seq_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // link signals
  input mode_e mode,
  input wire logic clk_en,
  input wire logic push_en,
  input wire logic pop_strobe,
  input wire logic empty,
  input wire logic full_rst,
  input wire logic read_pointer_clear,
  input wire logic chip_wide_init,
  input wire logic init_en,
  input wire logic sync_rst
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic any_rst;
  // any of the three asynchronous resets
  assign any_rst = full_rst || read_pointer_clear || chip_wide_init;
  // all enables held off
  sequence quiet_s;
    !clk_en && !push_en && !pop_strobe;
  endsequence
  // no asynchronous reset driven
  sequence released_s;
    !full_rst && !read_pointer_clear && !chip_wide_init;
  endsequence
  a_gate_before: assert property ($rose(full_rst) && !push_en |-> $past(!clk_en && !pop_strobe))
    else $error("enables not low before reset");
  a_gate_after: assert property ($rose(full_rst) && !push_en |-> quiet_s ##1 (quiet_s and released_s))
    else $error("enables not low around reset release");
  a_ptr_gate: assert property ($rose(read_pointer_clear) && !pop_strobe |-> $past(!pop_strobe) ##1 !pop_strobe)
    else $error("pop not held off around pointer clear");
  a_rst_spaced: assert property ($rose(any_rst) |-> $past(!any_rst) && $past(!any_rst, 2))
    else $error("reset raised without a quiet cycle before it");
  a_one_kind: assert property ($onehot0({full_rst, read_pointer_clear, chip_wide_init}))
    else $error("two reset kinds driven at once");
  a_hold_one: assert property (any_rst |=> !any_rst)
    else $error("reset held longer than one cycle");
  a_rom_preload: assert property (mode == MODE_ROM |-> !init_en && !chip_wide_init)
    else $error("chip-wide init live on preloaded contents");
  a_fifo_init: assert property (mode == MODE_FIFO |-> init_en)
    else $error("chip-wide init disabled in fifo mode");
  a_async_clear: assert property (full_rst || (chip_wide_init && init_en) |-> empty)
    else $error("pointers not cleared during reset");
  a_sync_pulse: assert property (sync_rst |-> released_s ##1 !sync_rst)
    else $error("sync reset not a lone pulse");
endmodule : rst_seq_checker

// *** hdl/block_ram_reset_sequencer.sv ***
// Purpose: user-side controller that sequences resets into the block RAM
// Assumes: reset requests may come from any domain; enables are local logic
// Notes: one full, pointer or init request is served at a time; others wait while BUSY is high; sync reset never waits
`timescale 1ns/10ps
module block_ram_reset_sequencer #(
  parameter int GUARD = ram_seq_pkg::GUARD_CYC,
  parameter int HOLD = ram_seq_pkg::RST_HOLD_CYC,
  parameter int STEADY = ram_seq_pkg::STEADY_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // configuration
  input ram_seq_pkg::mode_e MODE,
  input wire logic INIT_ENABLE,
  input wire logic KEEP_ENABLES,
  // reset requests, asynchronous levels
  input wire logic REQ_FULL_RST,
  input wire logic REQ_RPTR_CLR,
  input wire logic REQ_INIT,
  input wire logic REQ_SYNC_RST,
  // user access
  input wire logic USER_CE,
  input wire logic USER_PUSH,
  input wire logic USER_POP,
  input wire logic [ram_seq_pkg::ADDR_W-1:0] USER_ADDR,
  input wire logic [ram_seq_pkg::DATA_W-1:0] USER_WDATA,
  // status
  output logic BUSY,
  output logic [ram_seq_pkg::DATA_W-1:0] USER_RDATA,
  output logic USER_FULL,
  output logic USER_EMPTY,
  // link to the block RAM
  ram_rst_if.seq LNK
);
  import ram_seq_pkg::*;
  localparam logic [CNT_W-1:0] GUARD_N = CNT_W'(GUARD);
  localparam logic [CNT_W-1:0] HOLD_N = CNT_W'(HOLD);
  localparam logic [CNT_W-1:0] STEADY_N = CNT_W'(STEADY);
  logic [3:0] req_meta_q;
  logic [3:0] req_sync_q;
  logic [3:0] req_prev_q;
  logic [3:0] req_rise;
  logic [2:0] pend_q;
  seq_state_e state_q;
  seq_state_e state_d;
  rst_kind_e kind_q;
  logic keep_q;
  logic [CNT_W-1:0] cnt_q;
  logic cnt_done;
  logic gate;
  logic rst_on;
  logic preloaded;
  logic [DATA_W-1:0] rdata_q;

  // two-flop synchroniser, the first stage feeds only the second
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_meta_q <= 4'h0;
      req_sync_q <= 4'h0;
    end else begin
      req_meta_q <= {REQ_SYNC_RST, REQ_INIT, REQ_RPTR_CLR, REQ_FULL_RST};
      req_sync_q <= req_meta_q;
    end
  end

  // rising edges of the synchronised requests
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_prev_q <= 4'h0;
    end else begin
      req_prev_q <= req_sync_q;
    end
  end
  assign req_rise = req_sync_q & ~req_prev_q;

  // preloaded contents must not be wiped by chip-wide init
  assign preloaded = (MODE == MODE_ROM);

  // pending requests; a new edge wins over the clear of its taking
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (req_rise[i]) begin
          pend_q[i] <= !(i == int'(KIND_INIT) && preloaded);
        end else if (state_q == SEQ_IDLE && state_d == SEQ_QUIESCE && kind_sel() == i) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // fixed priority: full reset, then pointer clear, then init
  function automatic int kind_sel();
    int k;
    k = 3;
    if (pend_q[0]) begin
      k = 0;
    end else if (pend_q[1]) begin
      k = 1;
    end else if (pend_q[2]) begin
      k = 2;
    end
    return k;
  endfunction : kind_sel

  assign cnt_done = (cnt_q <= CNT_ONE);

  // sequencing state machine, same walk for ram, rom and fifo
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE: begin
        if (pend_q != 3'h0) begin
          state_d = SEQ_QUIESCE;
        end
      end
      SEQ_QUIESCE: begin
        if (cnt_done) begin
          state_d = SEQ_ASSERT;
        end
      end
      SEQ_ASSERT: begin
        if (cnt_done) begin
          state_d = keep_q ? SEQ_SETTLE : SEQ_RELEASE;
        end
      end
      SEQ_SETTLE: begin
        if (cnt_done) begin
          state_d = SEQ_IDLE;
        end
      end
      SEQ_RELEASE: begin
        if (cnt_done) begin
          state_d = SEQ_IDLE;
        end
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // kind and enable policy latched for the whole sequence
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      kind_q <= KIND_FULL;
      keep_q <= 1'b0;
    end else if (state_q == SEQ_IDLE && state_d == SEQ_QUIESCE) begin
      kind_q <= rst_kind_e'(2'(kind_sel()));
      keep_q <= KEEP_ENABLES;
    end
  end

  // phase counter; steady wait replaces the guard when enables stay on
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= CNT_ZERO;
    end else if (state_d != state_q) begin
      case (state_d)
        SEQ_QUIESCE: cnt_q <= KEEP_ENABLES ? STEADY_N : GUARD_N;
        SEQ_ASSERT: cnt_q <= HOLD_N;
        SEQ_SETTLE: cnt_q <= STEADY_N;
        SEQ_RELEASE: cnt_q <= GUARD_N;
        default: cnt_q <= CNT_ZERO;
      endcase
    end else if (cnt_q != CNT_ZERO) begin
      cnt_q <= cnt_q - CNT_ONE;
    end
  end

  // unless keep_q is set, enables are held off from quiesce through the GUARD cycles past release
  assign gate = !keep_q && (state_q == SEQ_QUIESCE || state_q == SEQ_ASSERT ||
                            state_q == SEQ_RELEASE);
  assign rst_on = (state_q == SEQ_ASSERT);
  // release on our edge, the ram sees it a full period before its next edge
  assign LNK.full_rst = rst_on && kind_q == KIND_FULL;
  assign LNK.read_pointer_clear = rst_on && kind_q == KIND_RPTR;
  assign LNK.chip_wide_init = rst_on && kind_q == KIND_INIT;
  // fifo always has init on; preloaded rom never
  assign LNK.init_en = (MODE == MODE_FIFO) | (INIT_ENABLE & !preloaded);

  // enable gating per kind: pointer clear leaves push open in fifo mode
  assign LNK.clk_en = USER_CE && !gate;
  assign LNK.pop_strobe = USER_POP && !gate;
  assign LNK.push_en = USER_PUSH && !(gate && (MODE != MODE_FIFO || kind_q != KIND_RPTR));
  assign LNK.mode = MODE;
  assign LNK.addr = USER_ADDR;
  assign LNK.wr_data = USER_WDATA;
  // sync reset passes straight through, it needs no quiet window
  assign LNK.sync_rst = req_rise[3];

  // read data registered for the user side
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= LNK.rd_data;
    end
  end
  assign USER_RDATA = rdata_q;
  assign USER_FULL = LNK.full;
  assign USER_EMPTY = LNK.empty;
  assign BUSY = (state_q != SEQ_IDLE) || (pend_q != 3'h0);
endmodule : block_ram_reset_sequencer

// *** hdl/embedded_block_ram.sv ***
// Purpose: block RAM end with async and sync reset inputs, RAM/ROM/FIFO modes
// Assumes: resets from the sequencer are already sequenced against enables
// Notes: contents are never cleared, only output register and pointers
`timescale 1ns/10ps
module embedded_block_ram #(
  parameter int DW = ram_seq_pkg::DATA_W,
  parameter int AW = ram_seq_pkg::ADDR_W
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // link to the sequencer
  ram_rst_if.ram LNK,
  // user side status
  output logic [DW:0] FILL_LEVEL
);
  import ram_seq_pkg::*;
  logic [DW-1:0] mem [2**AW];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic [DW-1:0] dout_q;
  logic init_live;
  logic clr_all;
  logic clr_rptr;
  logic is_fifo;
  logic [AW:0] fill_cnt;

  // fifo mode forces chip-wide init on whatever the config says
  assign is_fifo = (LNK.mode == MODE_FIFO);
  assign init_live = LNK.chip_wide_init & (LNK.init_en | is_fifo);
  // no clock in these paths: the reset reaches the flops directly
  assign clr_all = ~RST_N | LNK.full_rst | init_live;
  assign clr_rptr = clr_all | LNK.read_pointer_clear;

  // storage write; rom mode ignores writes
  always_ff @(posedge CORE_CLK) begin
    if (is_fifo) begin
      if (LNK.push_en && !LNK.full) begin
        mem[wptr_q[AW-1:0]] <= LNK.wr_data;
      end
    end else if (LNK.mode == MODE_RAM && LNK.clk_en && LNK.push_en) begin
      mem[LNK.addr] <= LNK.wr_data;
    end
  end

  // write pointer, cleared by RST_N, the full reset and a live chip-wide init
  always_ff @(posedge CORE_CLK or posedge clr_all) begin
    if (clr_all) begin
      wptr_q <= '0;
    end else if (is_fifo && LNK.push_en && !LNK.full) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  // read pointer, also cleared on its own
  always_ff @(posedge CORE_CLK or posedge clr_rptr) begin
    if (clr_rptr) begin
      rptr_q <= '0;
    end else if (is_fifo && LNK.pop_strobe && !LNK.empty) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end

  // output register: async clear, plus a sync clear needing no sequencing
  always_ff @(posedge CORE_CLK or posedge clr_all) begin
    if (clr_all) begin
      dout_q <= '0;
    end else if (LNK.sync_rst) begin
      dout_q <= '0;
    end else if (is_fifo) begin
      if (LNK.pop_strobe && !LNK.empty) begin
        dout_q <= mem[rptr_q[AW-1:0]];
      end
    end else if (LNK.clk_en) begin
      dout_q <= mem[LNK.addr];
    end
  end

  // flags from pointers; a pointer clear alone can leave a stale fill
  assign LNK.rd_data = dout_q;
  assign LNK.empty = (wptr_q == rptr_q);
  assign LNK.full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  // difference kept at pointer width, so a wrapped write pointer still counts right
  assign fill_cnt = wptr_q - rptr_q;
  assign FILL_LEVEL = (DW + 1)'(fill_cnt);
endmodule : embedded_block_ram

// *** hdl/ram_rst_if.sv ***
// Purpose: link between the reset sequencer and the block RAM
// Assumes: both ends run on CORE_CLK
// Notes: sequencer drives controls, RAM answers with data and flags
`timescale 1ns/10ps
interface ram_rst_if;
  import ram_seq_pkg::*;
  mode_e mode;
  logic clk_en;
  logic push_en;
  logic pop_strobe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic full;
  logic empty;
  logic full_rst;
  logic read_pointer_clear;
  logic chip_wide_init;
  logic init_en;
  logic sync_rst;
  modport seq (
    output mode, clk_en, push_en, pop_strobe, addr, wr_data,
    output full_rst, read_pointer_clear, chip_wide_init, init_en, sync_rst,
    input rd_data, full, empty
  );
  modport ram (
    input mode, clk_en, push_en, pop_strobe, addr, wr_data,
    input full_rst, read_pointer_clear, chip_wide_init, init_en, sync_rst,
    output rd_data, full, empty
  );
endinterface : ram_rst_if

// *** hdl/ram_seq_pkg.sv ***
// Purpose: shared constants and types for the block RAM reset sequencer pair
// Assumes: one 100 MHz clock shared by the sequencer and the block RAM
package ram_seq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAM_FMAX_MHZ = 100; // plain default, set for the real RAM
  localparam int STEADY_NS = (1000 + RAM_FMAX_MHZ - 1) / RAM_FMAX_MHZ;
  // least time, rounded up, never below one cycle
  localparam int STEADY_CYC_RAW = (STEADY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEADY_CYC = (STEADY_CYC_RAW < 1) ? 1 : STEADY_CYC_RAW;
  localparam int GUARD_CYC = 1;
  localparam int RST_HOLD_CYC = 1;
  localparam int CNT_W = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  typedef enum logic [1:0] {
    MODE_RAM = 2'b00,
    MODE_ROM = 2'b01,
    MODE_FIFO = 2'b10
  } mode_e;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_QUIESCE = 3'b001,
    SEQ_ASSERT = 3'b010,
    SEQ_SETTLE = 3'b011,
    SEQ_RELEASE = 3'b100
  } seq_state_e;
  typedef enum logic [1:0] {
    KIND_FULL = 2'b00,
    KIND_RPTR = 2'b01,
    KIND_INIT = 2'b10
  } rst_kind_e;
endpackage : ram_seq_pkg
